// *** scg_pkg.sv ***
// Package with register indices, field positions, reset values and encodings.
`default_nettype none
package scg_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [9:0] IDX_CONTROL    = 10'h200;
    localparam logic [9:0] IDX_FEEDBACK   = 10'h201;
    localparam logic [9:0] IDX_REF_PATH   = 10'h202;
    localparam logic [9:0] IDX_OUTDIV_CFG = 10'h240;
    localparam logic [9:0] IDX_SRC_PHASE  = 10'h241;
    localparam int CTL_SYNC_BIT     = 2;
    localparam int CTL_PDN_BIT      = 1;
    localparam int CTL_RST_BIT      = 0;
    localparam int REF_PREDIV_LSB   = 1;
    localparam int REF_DOUBLER_BIT  = 0;
    localparam int ODC_RSVD_BIT     = 7;
    localparam int ODC_PDN_BIT      = 6;
    localparam int SRC_PAIRED_BIT   = 7;
    localparam int SRC_TEN_BIT      = 6;
    localparam logic [7:0] RST_CONTROL    = 8'h00;
    localparam logic [7:0] RST_FEEDBACK   = 8'h10;
    localparam logic [7:0] RST_REF_PATH   = 8'h01;
    localparam logic [7:0] RST_OUTDIV_CFG = 8'h83;
    localparam logic [7:0] RST_SRC_PHASE  = 8'h00;
    localparam logic [7:0] MASK_CONTROL   = 8'h07;
    localparam logic [7:0] MASK_REF_PATH  = 8'h0f;
    localparam logic [2:0] PREDIV_OFF     = 3'h0;
    typedef logic [2:0] scg_prediv_t;
endpackage
`default_nettype wire

// *** scg_ref_path.sv ***
// Reference predivider and input path selection of the integer synthesizer.
`timescale 1ns/1ns
`default_nettype none
module scg_ref_path (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ref_edge,
    input  wire scg_pkg::scg_prediv_t ratio_code,
    input  wire logic              doubler_sel,
    output logic                   path_tick
);
    import scg_pkg::*;

    logic [4:0] half_len;
    logic [4:0] cnt_q;
    logic       pre_tick;

    // Divide ratios held in half input cycles: 1, 1.5, 2, 3, 4, 6, 8.
    always_comb begin
        unique case (ratio_code)
            3'h1:    half_len = 5'h02;
            3'h2:    half_len = 5'h03;
            3'h3:    half_len = 5'h04;
            3'h4:    half_len = 5'h06;
            3'h5:    half_len = 5'h08;
            3'h6:    half_len = 5'h0c;
            3'h7:    half_len = 5'h10;
            default: half_len = 5'h00;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 5'h00;
        end else if (ratio_code == PREDIV_OFF) begin
            cnt_q <= 5'h00;
        end else if (ref_edge) begin
            cnt_q <= (cnt_q + 5'h01 >= half_len) ? 5'h00 : cnt_q + 5'h01;
        end
    end

    assign pre_tick = ref_edge && (ratio_code != PREDIV_OFF) && (cnt_q == 5'h00);

    // The doubled clock rises on every edge of the reference.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            path_tick <= 1'b0;
        end else begin
            path_tick <= doubler_sel ? ref_edge : pre_tick;
        end
    end
endmodule
`default_nettype wire

// *** scg_out_divider.sv ***
// Output divider with divide by field plus one and half-cycle phase offset.
`timescale 1ns/1ns
`default_nettype none
module scg_out_divider #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         in_edge,
    input  wire logic         hold,
    input  wire logic         power_down,
    input  wire logic [W-1:0] ratio,
    input  wire logic [W-1:0] phase,
    output logic              div_out
);
    logic [W:0]   half_q;
    logic [W-1:0] delay_q;
    logic         held_q;

    // The output toggles every ratio+1 input half cycles, so it divides by ratio+1.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            half_q  <= '0;
            delay_q <= '0;
            held_q  <= 1'b1;
            div_out <= 1'b0;
        end else if (power_down || hold) begin
            half_q  <= '0;
            delay_q <= '0;
            held_q  <= 1'b1;
            div_out <= 1'b0;
        end else if (held_q) begin
            delay_q <= phase;
            held_q  <= 1'b0;
        end else if (in_edge) begin
            if (delay_q != '0) begin
                delay_q <= delay_q - 1'b1;
            end else if (half_q == {1'b0, ratio}) begin
                half_q  <= '0;
                div_out <= ~div_out;
            end else begin
                half_q <= half_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** scg_synth_config.sv ***
// Integer synthesizer configuration and first distribution stage with APB registers.
//
// Behaviour
// - The distribution sync bit holds every divider fed by the synthesizer in sync while set; here it holds only the output divider, not the feedback divider.
// - The feedback divider divides by its 8-bit field, reset 16, and only 4 to 255 are legal.
// - The predivider code 000 powers it down and 001 to 111 divide by 1, 1.5, 2, 3, 4, 6 and 8.
// - Reference path bit 0 picks the predivider output when 0 and the doubler when 1, reset 1.
// - The output divider divides by its 6-bit field plus one, reset field 3.
// - The output divider delays its output by the phase field in half input cycles, reset 0.
// - Source bit 7 routes outputs eight and nine to the output divider or the active reference.
// - Source bit 6 feeds output ten's divider from the synthesizer or the first shared divider.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module scg_synth_config (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [scg_pkg::ADDR_W-1:0] paddr,
    input  wire logic [scg_pkg::DATA_W-1:0] pwdata,
    output logic      [scg_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       ref_edge,
    input  wire logic                       active_ref_clk,
    input  wire logic                       synth_out_edge,
    input  wire logic                       synth_out_rise,
    input  wire logic                       first_shared_divider_edge,
    output logic                            synth_reset,
    output logic                            synth_power_down,
    output logic                            distribution_sync,
    output logic                            synth_input_tick,
    output logic                            feedback_tick,
    output logic [7:0]                      feedback_divide,
    output logic                            output_divider_clk,
    output logic                            paired_output_clk,
    output logic                            output_ten_div_edge
);
    import scg_pkg::*;

    logic [7:0] control_q;
    logic [7:0] feedback_q;
    logic [7:0] ref_path_q;
    logic [7:0] outdiv_cfg_q;
    logic [7:0] src_phase_q;
    logic [9:0] index;
    logic       aligned;
    logic       hit;
    logic       access;
    logic [7:0] rd_byte;
    logic [7:0] fb_cnt_q;
    logic       synth_held;

    assign index   = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign access  = psel && penable;

    always_comb begin
        hit     = aligned;
        rd_byte = 8'h00;
        unique case (index)
            IDX_CONTROL:    rd_byte = control_q;
            IDX_FEEDBACK:   rd_byte = feedback_q;
            IDX_REF_PATH:   rd_byte = ref_path_q;
            IDX_OUTDIV_CFG: rd_byte = outdiv_cfg_q;
            IDX_SRC_PHASE:  rd_byte = src_phase_q;
            default:        hit     = 1'b0;
        endcase
    end

    // The slave answers in the first access cycle; unmapped addresses return an error.
    assign pready  = 1'b1;
    assign pslverr = access && !hit;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, rd_byte};
        end
    end

    // Reserved bits of the control and reference path registers read as zero.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            control_q    <= RST_CONTROL;
            feedback_q   <= RST_FEEDBACK;
            ref_path_q   <= RST_REF_PATH;
            outdiv_cfg_q <= RST_OUTDIV_CFG;
            src_phase_q  <= RST_SRC_PHASE;
        end else if (access && pwrite && hit) begin
            unique case (index)
                IDX_CONTROL:    control_q    <= pwdata[7:0] & MASK_CONTROL;
                IDX_FEEDBACK:   feedback_q   <= pwdata[7:0];
                IDX_REF_PATH:   ref_path_q   <= pwdata[7:0] & MASK_REF_PATH;
                IDX_OUTDIV_CFG: outdiv_cfg_q <= pwdata[7:0];
                default:        src_phase_q  <= pwdata[7:0];
            endcase
        end
    end

    assign synth_reset       = control_q[CTL_RST_BIT];
    assign synth_power_down  = control_q[CTL_PDN_BIT];
    assign distribution_sync = control_q[CTL_SYNC_BIT];
    assign feedback_divide   = feedback_q;
    assign synth_held        = synth_reset || synth_power_down;

    scg_ref_path u_ref_path (
        .clk         (clk),
        .reset       (reset),
        .ref_edge    (ref_edge),
        .ratio_code  (ref_path_q[REF_PREDIV_LSB +: 3]),
        .doubler_sel (ref_path_q[REF_DOUBLER_BIT]),
        .path_tick   (synth_input_tick)
    );

    // Feedback divider emits one tick per feedback_divide rising edges of the synthesizer.
    // Values below four are illegal and are not corrected here.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fb_cnt_q      <= 8'h00;
            feedback_tick <= 1'b0;
        end else if (synth_held) begin
            fb_cnt_q      <= 8'h00;
            feedback_tick <= 1'b0;
        end else if (synth_out_rise) begin
            if (fb_cnt_q + 8'h01 >= feedback_q) begin
                fb_cnt_q      <= 8'h00;
                feedback_tick <= 1'b1;
            end else begin
                fb_cnt_q      <= fb_cnt_q + 8'h01;
                feedback_tick <= 1'b0;
            end
        end else begin
            feedback_tick <= 1'b0;
        end
    end

    scg_out_divider #(
        .W (6)
    ) u_out_divider (
        .clk        (clk),
        .reset      (reset),
        .in_edge    (synth_out_edge),
        .hold       (distribution_sync || synth_held),
        .power_down (outdiv_cfg_q[ODC_PDN_BIT]),
        .ratio      (outdiv_cfg_q[5:0]),
        .phase      (src_phase_q[5:0]),
        .div_out    (output_divider_clk)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            paired_output_clk   <= 1'b0;
            output_ten_div_edge <= 1'b0;
        end else begin
            paired_output_clk   <= src_phase_q[SRC_PAIRED_BIT] ? active_ref_clk
                                                               : output_divider_clk;
            output_ten_div_edge <= src_phase_q[SRC_TEN_BIT] ? first_shared_divider_edge
                                                            : synth_out_edge;
        end
    end
endmodule
`default_nettype wire

// *** scg_synth_config_props.sv ***
// Assertion checker for the synthesizer configuration block.
`timescale 1ns/1ns
`default_nettype none
module scg_synth_config_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ref_edge,
    input wire logic synth_out_edge,
    input wire logic synth_out_rise,
    input wire logic first_shared_divider_edge,
    input wire logic synth_reset,
    input wire logic synth_power_down,
    input wire logic distribution_sync,
    input wire logic synth_input_tick,
    input wire logic feedback_tick,
    input wire logic output_divider_clk,
    input wire logic output_ten_div_edge
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // A control level that has stood for two samples has reached the dividers.
    sequence s_two(x);
        x ##1 x;
    endsequence
    a_sync_holds_low: assert property (s_two(distribution_sync) |->
        !output_divider_clk)
        else $error("output divider ran during sync");
    a_pdn_stops_all: assert property (s_two(synth_power_down) |->
        !output_divider_clk && !feedback_tick)
        else $error("activity during power-down");
    a_reset_stops_all: assert property (s_two(synth_reset) |->
        !feedback_tick && !output_divider_clk)
        else $error("activity during synthesizer reset");
    a_fb_after_rise: assert property (feedback_tick |-> $past(synth_out_rise))
        else $error("feedback tick without input rise");
    a_tick_has_ref: assert property (synth_input_tick |-> $past(ref_edge))
        else $error("input tick without reference edge");
    a_div_rise_cause: assert property ($rose(output_divider_clk) |->
        $past(synth_out_edge))
        else $error("output divider rose without input edge");
    a_ten_edge_cause: assert property (output_ten_div_edge |->
        $past(synth_out_edge) || $past(first_shared_divider_edge))
        else $error("output ten edge without a source edge");
    a_slverr_in_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    a_ready_in_access: assert property (psel && penable |-> pready)
        else $error("access phase not ready");
endmodule
bind scg_synth_config scg_synth_config_props u_props (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .ref_edge(ref_edge),
    .synth_out_edge(synth_out_edge), .synth_out_rise(synth_out_rise),
    .first_shared_divider_edge(first_shared_divider_edge), .synth_reset(synth_reset),
    .synth_power_down(synth_power_down), .distribution_sync(distribution_sync),
    .synth_input_tick(synth_input_tick), .feedback_tick(feedback_tick),
    .output_divider_clk(output_divider_clk), .output_ten_div_edge(output_ten_div_edge));
`default_nettype wire

// *** tb_scg_synth_config.sv ***
// Self-checking testbench for the synthesizer configuration block.
`timescale 1ns/1ns
`default_nettype none
module tb_scg_synth_config;
    import scg_pkg::*;
    logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, e, odp = 0;
    logic        re = 0, ar = 0, oe = 0, ri = 0, fe = 0, pready, pslverr;
    logic        srs, spd, dsy, sit, fbt, odc, poc, ted;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [7:0]  fbd, v, p;
    int          error_cnt = 0, tests_run = 0, cyc = 0, nin = 0, nfb = 0, nten = 0;
    int          nr = 0, fr = 0, per = 0, lr = 0, st, dz, i;
    logic [9:0]  ix [5] = '{IDX_CONTROL, IDX_FEEDBACK, IDX_REF_PATH,
                            IDX_OUTDIV_CFG, IDX_SRC_PHASE};
    logic [7:0]  rv [5] = '{8'h00, 8'h10, 8'h01, 8'h83, 8'h00};
    logic [7:0]  mk [5] = '{8'h07, 8'hff, 8'h0f, 8'hff, 8'hff};
    int          pw [8] = '{0, 2, 3, 4, 6, 8, 12, 16};
    always #10 clk = ~clk;
    scg_synth_config uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_edge(re), .active_ref_clk(ar), .synth_out_edge(oe),
        .synth_out_rise(ri), .first_shared_divider_edge(fe), .synth_reset(srs),
        .synth_power_down(spd), .distribution_sync(dsy), .synth_input_tick(sit),
        .feedback_tick(fbt), .feedback_divide(fbd), .output_divider_clk(odc),
        .paired_output_clk(poc), .output_ten_div_edge(ted));
    // Outputs are counted mid-cycle, where they have settled.
    always @(negedge clk) begin
        cyc++;
        nin += sit;
        nfb += fbt;
        nten += ted;
        if (odc && !odp) begin
            if (nr == 0) fr = cyc;
            per = cyc - lr;
            lr = cyc;
            nr++;
        end
        odp = odc;
    end
    function int ticks(int c);
        return c > 7 ? 48 : (c > 0 ? 48 / pw[c] : 0);
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task final_report;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        final_report;
    end
    initial begin
        i = $urandom(3408);
        tk(3);
        reset <= 0;
        tk(1);
        for (i = 0; i < 5; i++) begin
            apb(0, ix[i], 0);
            chk(q, rv[i]);
            v = 8'($urandom);
            if (i == 1) v = 8'($urandom_range(255, 4));
            if (i == 3) v[7] = 1'b1;
            apb(1, ix[i], v);
            if (i == 0) chk({dsy, spd, srs}, v[2:0]);
            apb(0, ix[i], 0);
            chk(q, v & mk[i]);
            apb(1, ix[i], rv[i]);
        end
        apb(0, 10'h203, 0);
        chk(e, 1);
        chk(q, 0);
        v = 8'($urandom_range(12, 4));
        apb(1, IDX_FEEDBACK, v);
        chk(fbd, v);
        apb(1, IDX_CONTROL, 8'h01);
        apb(1, IDX_CONTROL, 8'h00);
        nfb = 0;
        ri <= 1;
        tk(3 * v);
        ri <= 0;
        tk(3);
        chk(nfb, 3);
        re <= 1;
        for (i = 0; i < 9; i++) begin
            apb(1, IDX_REF_PATH, i < 8 ? 8'(2 * i) : 8'h0f);
            tk(20);
            nin = 0;
            tk(48);
            chk(nin, ticks(i));
        end
        for (i = 0; i < 2; i++) begin
            apb(1, IDX_SRC_PHASE, {1'b0, i[0], 6'h0});
            oe <= 1;
            fe <= 0;
            tk(3);
            nten = 0;
            tk(20);
            chk(nten, i ? 0 : 20);
            oe <= 0;
            fe <= 1;
            tk(3);
            nten = 0;
            tk(20);
            chk(nten, i ? 20 : 0);
        end
        fe <= 0;
        oe <= 1;
        v = 8'($urandom_range(5, 1));
        p = 8'($urandom_range(9, 1));
        for (i = 0; i < 2; i++) begin
            apb(1, IDX_CONTROL, 8'h04);
            apb(1, IDX_OUTDIV_CFG, 8'h80 | v);
            apb(1, IDX_SRC_PHASE, i ? p : 8'h0);
            nr = 0;
            tk(20);
            chk(nr, 0);
            apb(1, IDX_CONTROL, 8'h00);
            st = cyc;
            tk(40 + 8 * v);
            if (i == 0) dz = fr - st;
            else chk(fr - st, dz + p);
            chk(per, 2 * (v + 1));
        end
        // Feedback rises keep coming, so a held synthesizer must swallow them.
        ri <= 1;
        for (i = 1; i < 4; i++) begin
            apb(1, IDX_CONTROL, 8'(i));
            nr = 0;
            nfb = 0;
            tk(20);
            chk(nr, 0);
            chk(nfb, 0);
        end
        ri <= 0;
        apb(1, IDX_CONTROL, 8'h00);
        apb(1, IDX_OUTDIV_CFG, 8'hc3);
        nr = 0;
        for (i = 0; i < 4; i++) begin
            apb(1, IDX_SRC_PHASE, {i[1], 7'h0});
            ar <= i[0];
            tk(3);
            chk(poc, i[1] & i[0]);
        end
        chk(nr, 0);
        final_report;
    end
endmodule
`default_nettype wire
